// file: src/three_pll_clock_synth.sv
/*
 * Three-loop clock synthesiser: APB register file, control pin functions,
 * crosspoint and glitch-free post dividers driving three clock outputs.
 * Assumes crystal_in_pin and freq_select_input are asynchronous pins and
 * an APB master on mclk; output enables drive the tri-state pad cells.
 */
// Decided for this implementation: the address map and the APB register port.
// Operation
// (R1) Each loop makes reference times p over q
// (R2) Control pin may switch first loop frequency
// (R3) Control pin has four programmable functions
// (R4) Pin level picks between two setting sets
// (R5) Divider changes apply only at period ends
// (R6) Suspend may act together with frequency select
// (R7) Output enable low floats all outputs
// (R8) Shutdown low floats outputs, stops everything
// (R9) Loops relock before outputs run again
// (R10) Six-bit crystal load capacitance code
// (R11) Load capacitors bypassable for driven reference
// (R12) Oscillator drive strength is programmable
// (R13) Any of four sources to any output
// (R14) Outputs A and B pick divider by level
// (R15) Output C uses one fixed divider setting
// (R16) Suspended loops need their outputs suspended too
// (R17) Suspend stops loops and floats chosen outputs
// (R18) Per-output inverted phase selection
// (R19) Post divider divides by its integer value
`timescale 1ns/1ps
`default_nettype none

module three_pll_clock_synth
   import clock_synth_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              crystal_in_pin,
   output logic                   crystal_feedback_pin,
   output logic                   crystal_feedback_pin_oe,
   input  wire logic              freq_select_input,
   output logic                   clock_out_a,
   output logic                   clock_out_a_oe,
   output logic                   clock_out_b,
   output logic                   clock_out_b_oe,
   output logic                   clock_out_c,
   output logic                   clock_out_c_oe,
   output logic      [CAP_W-1:0]  cap_load_code,
   output logic                   cap_bypass,
   output logic      [DRIVE_W-1:0] osc_drive
);

   // Register index decode, shared by read and write paths
   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      case (a)
         ADDR_CTRL, ADDR_XTAL, ADDR_LOOP1_S0, ADDR_LOOP2, ADDR_LOOP3,
         ADDR_LOOP1_S1, ADDR_XBAR, ADDR_DIV_A, ADDR_DIV_B, ADDR_DIV_C,
         ADDR_STATUS:
            addr_known = 1'b1;
         default:
            addr_known = 1'b0;
      endcase
   endfunction : addr_known

   logic [CTRL_W-1:0] ctrl_q;
   logic [XTAL_W-1:0] xtal_q;
   logic [LOOP_W-1:0] loop1_s0_q;
   logic [LOOP_W-1:0] loop1_s1_q;
   logic [LOOP_W-1:0] loop2_q;
   logic [LOOP_W-1:0] loop3_q;
   logic [5:0]        xbar_q;
   logic [DIVR_W-1:0] div_a_q;
   logic [DIVR_W-1:0] div_b_q;
   logic [DIVR_W-1:0] div_c_q;
   logic [DATA_W-1:0] prdata_q;
   logic              pready_q;
   logic              pslverr_q;
   logic [DATA_W-1:0] rd_mux;
   logic              wr_en;

   logic [1:0]        fs_sync_q;
   logic [2:0]        xtal_sync_q;
   logic              xtal_fb_q;
   logic              xtal_fb_oe_q;
   logic              ref_rise;
   logic              ref_edge;

   logic [1:0]        pin_mode;
   logic              pin_lvl;
   logic              fs_lvl;
   logic              suspend_on;
   logic              float_all;
   logic              shutdown_on;

   logic [NUM_LOOPS-1:0] loop_en;
   logic [NUM_LOOPS-1:0] loop_tick;
   logic [NUM_LOOPS-1:0] loop_locked;
   logic [LOOP_W-1:0]    loop_cfg [NUM_LOOPS];
   logic [NUM_OUTS-1:0]  out_clk;
   logic [NUM_OUTS-1:0]  out_oe;

   // APB slave with one wait state; read data latched on the same edge that raises pready
   assign wr_en = psel && penable && pready_q && pwrite && addr_known(paddr);

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end
      else
      begin
         pready_q <= psel && penable && !pready_q;
         if (psel && penable && !pready_q)
         begin
            pslverr_q <= !addr_known(paddr);
            prdata_q  <= pwrite ? '0 : rd_mux;
         end
         else
         begin
            pslverr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         ctrl_q     <= CTRL_RESET;
         xtal_q     <= XTAL_RESET;
         loop1_s0_q <= LOOP_RESET;
         loop1_s1_q <= LOOP_RESET;
         loop2_q    <= LOOP_RESET;
         loop3_q    <= LOOP_RESET;
         xbar_q     <= XBAR_RESET;
         div_a_q    <= DIV_RESET;
         div_b_q    <= DIV_RESET;
         div_c_q    <= {8'h00, DIV_RESET[DIV_W-1:0]};
      end
      else if (wr_en)
      begin
         case (paddr)
            ADDR_CTRL:     ctrl_q     <= pwdata[CTRL_W-1:0];   // [R3] [R6] [R18]
            ADDR_XTAL:     xtal_q     <= pwdata[XTAL_W-1:0];   // [R10] [R11] [R12]
            ADDR_LOOP1_S0: loop1_s0_q <= pwdata[LOOP_W-1:0];
            ADDR_LOOP1_S1: loop1_s1_q <= pwdata[LOOP_W-1:0];
            ADDR_LOOP2:    loop2_q    <= pwdata[LOOP_W-1:0];
            ADDR_LOOP3:    loop3_q    <= pwdata[LOOP_W-1:0];
            ADDR_XBAR:     xbar_q     <= pwdata[5:0];
            ADDR_DIV_A:    div_a_q    <= pwdata[DIVR_W-1:0];
            ADDR_DIV_B:    div_b_q    <= pwdata[DIVR_W-1:0];
            ADDR_DIV_C:    div_c_q    <= {8'h00, pwdata[DIV_W-1:0]};   // [R15]
            default:       ctrl_q     <= ctrl_q;
         endcase
      end
   end

   always_comb
   begin
      rd_mux = '0;
      case (paddr)
         ADDR_CTRL:     rd_mux = DATA_W'(ctrl_q);
         ADDR_XTAL:     rd_mux = DATA_W'(xtal_q);
         ADDR_LOOP1_S0: rd_mux = DATA_W'(loop1_s0_q);
         ADDR_LOOP1_S1: rd_mux = DATA_W'(loop1_s1_q);
         ADDR_LOOP2:    rd_mux = DATA_W'(loop2_q);
         ADDR_LOOP3:    rd_mux = DATA_W'(loop3_q);
         ADDR_XBAR:     rd_mux = DATA_W'(xbar_q);
         ADDR_DIV_A:    rd_mux = DATA_W'(div_a_q);
         ADDR_DIV_B:    rd_mux = DATA_W'(div_b_q);
         ADDR_DIV_C:    rd_mux = DATA_W'(div_c_q);
         ADDR_STATUS:
         begin
            rd_mux[ST_FS_LVL]                     = fs_lvl;
            rd_mux[ST_LOCK_LSB +: NUM_LOOPS]      = loop_locked;
            rd_mux[ST_SHUTDOWN]                   = shutdown_on;
            rd_mux[ST_SUSPEND]                    = suspend_on;
            rd_mux[ST_OE_LSB +: NUM_OUTS]         = out_oe;
         end
         default:       rd_mux = '0;
      endcase
   end

   // Pin synchronisers; freq select reads its second stage, crystal its second and third
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         fs_sync_q   <= '0;
         xtal_sync_q <= '0;
      end
      else
      begin
         fs_sync_q   <= {fs_sync_q[0], freq_select_input};
         xtal_sync_q <= {xtal_sync_q[1:0], crystal_in_pin};
      end
   end

   assign ref_rise = xtal_sync_q[1] && !xtal_sync_q[2];
   assign ref_edge = xtal_sync_q[1] ^ xtal_sync_q[2];

   // Control pin function decode
   assign pin_mode    = ctrl_q[CTRL_MODE_LSB +: 2];
   assign pin_lvl     = fs_sync_q[1];
   assign fs_lvl      = (pin_mode == MODE_FREQ_SEL) && pin_lvl;   // [R2] [R4]
   assign suspend_on  = !pin_lvl && ((pin_mode == MODE_SUSPEND) ||
                        ((pin_mode == MODE_FREQ_SEL) && ctrl_q[CTRL_SUSP_ALSO]));   // [R6]
   assign float_all   = !pin_lvl && (pin_mode == MODE_OUT_EN);   // [R7]
   assign shutdown_on = !pin_lvl && (pin_mode == MODE_SHUTDOWN);   // [R8]

   // Oscillator feedback: inverted reference, released when bypassed
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         xtal_fb_q    <= 1'b0;
         xtal_fb_oe_q <= 1'b0;
      end
      else
      begin
         xtal_fb_q    <= !xtal_sync_q[1];
         xtal_fb_oe_q <= !xtal_q[XTAL_BYPASS] && !shutdown_on;   // [R8] [R11]
      end
   end

   assign crystal_feedback_pin    = xtal_fb_q;
   assign crystal_feedback_pin_oe = xtal_fb_oe_q;
   assign cap_load_code           = xtal_q[XTAL_CAP_LSB +: CAP_W];   // [R10]
   assign cap_bypass              = xtal_q[XTAL_BYPASS];   // [R11]
   assign osc_drive               = xtal_q[XTAL_DRIVE_LSB +: DRIVE_W];   // [R12]

   assign loop_cfg[0] = fs_lvl ? loop1_s1_q : loop1_s0_q;   // [R4]
   assign loop_cfg[1] = loop2_q;
   assign loop_cfg[2] = loop3_q;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_LOOPS; gi++)
      begin : g_loop
         // A suspended or shut down loop loses lock and must relock
         assign loop_en[gi] = !shutdown_on &&
                              !(suspend_on && ctrl_q[CTRL_SUSP_LOOP_LSB + gi]);   // [R8] [R17] [R9]

         synth_loop u_loop (   // [R1]
            .mclk    (mclk),
            .reset_n (reset_n),
            .enable  (loop_en[gi]),
            .ref_tick(ref_rise),
            .q       (loop_cfg[gi][LOOP_Q_LSB +: Q_W]),
            .p       (loop_cfg[gi][LOOP_P_LSB +: P_W]),
            .tick    (loop_tick[gi]),
            .locked  (loop_locked[gi])
         );
      end

      for (gi = 0; gi < NUM_OUTS; gi++)
      begin : g_out
         logic [SEL_W-1:0] src_sel;
         logic             src_tick;
         logic [DIV_W-1:0] div_want;
         logic [DIV_W-1:0] div_cur_q;
         logic [DIV_W-1:0] cnt_q;
         logic             half_q;
         logic             run;
         logic             out_q;
         logic             oe_q;

         assign src_sel = xbar_q[gi*SEL_W +: SEL_W];

         // Crosspoint: reference or any loop to this output
         always_comb
         begin
            case (src_sel)   // [R13]
               SRC_REF:   src_tick = ref_edge;
               SRC_LOOP1: src_tick = loop_tick[0];
               SRC_LOOP2: src_tick = loop_tick[1];
               SRC_LOOP3: src_tick = loop_tick[2];
               default:   src_tick = 1'b0;
            endcase
         end

         if (gi < 2)
         begin : g_sel
            logic [DIVR_W-1:0] div_reg;
            assign div_reg  = (gi == 0) ? div_a_q : div_b_q;
            assign div_want = fs_lvl ? div_reg[DIV_S1_LSB +: DIV_W]
                                     : div_reg[DIV_S0_LSB +: DIV_W];   // [R14]
         end
         else
         begin : g_fix
            assign div_want = div_c_q[DIV_S0_LSB +: DIV_W];   // [R15]
         end

         // Suspending a loop without its outputs is a programming error
         assign run = !shutdown_on &&
                      !(suspend_on && ctrl_q[CTRL_SUSP_OUT_LSB + gi]) &&
                      (div_cur_q != '0);   // [R16] [R17]

         // Toggle every div_cur ticks; while running, reload only after a half with half_q high
         always_ff @(posedge mclk)
         begin
            if (!reset_n)
            begin
               cnt_q     <= '0;
               half_q    <= 1'b0;
               div_cur_q <= DIV_RESET[DIV_W-1:0];
            end
            else if (!run)
            begin
               cnt_q     <= '0;
               half_q    <= 1'b0;
               div_cur_q <= div_want;
            end
            else if (src_tick)
            begin
               if (cnt_q + DIV_W'(1) >= div_cur_q)   // [R19]
               begin
                  cnt_q  <= '0;
                  half_q <= !half_q;
                  if (half_q)
                     div_cur_q <= div_want;   // [R5]
               end
               else
               begin
                  cnt_q <= cnt_q + DIV_W'(1);
               end
            end
         end

         always_ff @(posedge mclk)
         begin
            if (!reset_n)
            begin
               out_q <= 1'b0;
               oe_q  <= 1'b0;
            end
            else
            begin
               out_q <= half_q ^ ctrl_q[CTRL_INV_LSB + gi];   // [R18]
               oe_q  <= !shutdown_on && !float_all &&
                        !(suspend_on && ctrl_q[CTRL_SUSP_OUT_LSB + gi]);   // [R7] [R8] [R17]
            end
         end

         assign out_clk[gi] = out_q;
         assign out_oe[gi]  = oe_q;
      end
   endgenerate

   assign clock_out_a    = out_clk[0];
   assign clock_out_a_oe = out_oe[0];
   assign clock_out_b    = out_clk[1];
   assign clock_out_b_oe = out_oe[1];
   assign clock_out_c    = out_clk[2];
   assign clock_out_c_oe = out_oe[2];
   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;

endmodule : three_pll_clock_synth

`default_nettype wire

// file: src/clock_synth_pkg.sv
/*
 * Constants shared by the three-loop clock synthesiser: register offsets,
 * field positions, reset values, control pin functions and lock timing.
 * Assumes a 32-bit APB register bus with byte addresses on an 8-bit paddr.
 */
package clock_synth_pkg;

   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned NUM_LOOPS  = 3;
   localparam int unsigned NUM_OUTS   = 3;
   localparam int unsigned Q_W        = 8;
   localparam int unsigned P_W        = 11;
   localparam int unsigned DIV_W      = 7;
   localparam int unsigned ACC_W      = 14;
   localparam int unsigned CAP_W      = 6;
   localparam int unsigned DRIVE_W    = 2;
   localparam int unsigned SEL_W      = 2;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_XTAL     = 8'h04;
   localparam logic [7:0] ADDR_LOOP1_S0 = 8'h08;
   localparam logic [7:0] ADDR_LOOP2    = 8'h0C;
   localparam logic [7:0] ADDR_LOOP3    = 8'h10;
   localparam logic [7:0] ADDR_LOOP1_S1 = 8'h14;
   localparam logic [7:0] ADDR_XBAR     = 8'h18;
   localparam logic [7:0] ADDR_DIV_A    = 8'h1C;
   localparam logic [7:0] ADDR_DIV_B    = 8'h20;
   localparam logic [7:0] ADDR_DIV_C    = 8'h24;
   localparam logic [7:0] ADDR_STATUS   = 8'h28;

   // Control register fields
   localparam int unsigned CTRL_MODE_LSB     = 0;
   localparam int unsigned CTRL_SUSP_ALSO    = 2;
   localparam int unsigned CTRL_SUSP_LOOP_LSB = 3;
   localparam int unsigned CTRL_SUSP_OUT_LSB = 6;
   localparam int unsigned CTRL_INV_LSB      = 9;
   localparam int unsigned CTRL_W            = 12;

   // Crystal register fields
   localparam int unsigned XTAL_CAP_LSB   = 0;
   localparam int unsigned XTAL_BYPASS    = 6;
   localparam int unsigned XTAL_DRIVE_LSB = 8;
   localparam int unsigned XTAL_W         = 10;

   // Loop setting fields
   localparam int unsigned LOOP_Q_LSB = 0;
   localparam int unsigned LOOP_P_LSB = 8;
   localparam int unsigned LOOP_W     = 19;

   // Post divider fields
   localparam int unsigned DIV_S0_LSB = 0;
   localparam int unsigned DIV_S1_LSB = 8;
   localparam int unsigned DIVR_W     = 15;

   // Status fields
   localparam int unsigned ST_FS_LVL   = 0;
   localparam int unsigned ST_LOCK_LSB = 1;
   localparam int unsigned ST_SHUTDOWN = 4;
   localparam int unsigned ST_SUSPEND  = 5;
   localparam int unsigned ST_OE_LSB   = 6;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h002;
   localparam logic [XTAL_W-1:0] XTAL_RESET = 10'h100;
   localparam logic [LOOP_W-1:0] LOOP_RESET = 19'h00101;
   localparam logic [5:0]        XBAR_RESET = 6'h00;
   localparam logic [DIVR_W-1:0] DIV_RESET  = 15'h0101;

   // Control pin functions
   localparam logic [1:0] MODE_FREQ_SEL = 2'h0;
   localparam logic [1:0] MODE_SUSPEND  = 2'h1;
   localparam logic [1:0] MODE_OUT_EN   = 2'h2;
   localparam logic [1:0] MODE_SHUTDOWN = 2'h3;

   // Crosspoint sources
   localparam logic [1:0] SRC_REF   = 2'h0;
   localparam logic [1:0] SRC_LOOP1 = 2'h1;
   localparam logic [1:0] SRC_LOOP2 = 2'h2;
   localparam logic [1:0] SRC_LOOP3 = 2'h3;

   // Reference periods counted before a loop reports lock
   localparam int unsigned LOCK_REF_TICKS = 16;
   localparam int unsigned LOCK_W         = 5;

endpackage : clock_synth_pkg

// file: src/synth_loop.sv
/*
 * One synthesis loop: a numerically controlled oscillator that yields
 * reference * p / q as half-period ticks on mclk, gated by a lock timer.
 * Assumes ref_tick is a one-cycle pulse per reference period on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module synth_loop
   import clock_synth_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           reset_n,
   input  wire logic           enable,
   input  wire logic           ref_tick,
   input  wire logic [Q_W-1:0] q,
   input  wire logic [P_W-1:0] p,
   output logic                tick,
   output logic                locked
);

   logic [ACC_W-1:0]  acc_q;
   logic [ACC_W-1:0]  acc_d;
   logic [LOCK_W-1:0] lock_cnt_q;
   logic              locked_q;
   logic              tick_q;
   logic              emit;
   logic              valid_cfg;

   assign valid_cfg = (q != '0) && (p != '0);
   assign emit      = valid_cfg && (acc_q >= ACC_W'(q));

   // Two half periods per output period, so 2p per reference period
   always_comb
   begin
      acc_d = acc_q;
      if (emit)
         acc_d = acc_d - ACC_W'(q);
      if (ref_tick && !acc_q[ACC_W-1])
         acc_d = acc_d + ACC_W'({p, 1'b0});
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n || !enable)
         acc_q <= '0;
      else
         acc_q <= acc_d;
   end

   // Lock is lost whenever the loop is stopped
   always_ff @(posedge mclk)
   begin
      if (!reset_n || !enable || !valid_cfg)
      begin
         lock_cnt_q <= '0;
         locked_q   <= 1'b0;
      end
      else if (ref_tick && !locked_q)
      begin
         lock_cnt_q <= lock_cnt_q + LOCK_W'(1);
         locked_q   <= (lock_cnt_q == LOCK_W'(LOCK_REF_TICKS - 1));
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n || !enable)
         tick_q <= 1'b0;
      else
         tick_q <= emit && locked_q;
   end

   assign tick   = tick_q;
   assign locked = locked_q;

endmodule : synth_loop

`default_nettype wire

// file: verif/clock_synth_sva.sv
/* Port checker for three_pll_clock_synth.
   Assumes it is bound by the statement at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module clock_synth_sva
   import clock_synth_pkg::*;
(
   input wire logic               mclk,
   input wire logic               reset_n,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [ADDR_W-1:0]  paddr,
   input wire logic [DATA_W-1:0]  pwdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               freq_select_input,
   input wire logic               clock_out_a_oe,
   input wire logic               clock_out_b_oe,
   input wire logic               clock_out_c_oe,
   input wire logic               crystal_feedback_pin_oe,
   input wire logic [CAP_W-1:0]   cap_load_code,
   input wire logic               cap_bypass,
   input wire logic [DRIVE_W-1:0] osc_drive
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   logic [CTRL_W-1:0] ctrl_q;
   logic [DATA_W-1:0] wdata_q;
   wire logic         wr = psel && penable && pready && pwrite;
   wire logic [2:0]   oe = {clock_out_c_oe, clock_out_b_oe, clock_out_a_oe};
   // Shadow of the control register
   always_ff @(posedge mclk)
   begin
      wdata_q <= pwdata;
      if (!reset_n)
         ctrl_q <= CTRL_RESET;
      else if (wr && paddr == ADDR_CTRL)
         ctrl_q <= pwdata[CTRL_W-1:0];
   end
   sequence access_start;
      psel && penable && !$past(penable);
   endsequence
   sequence pin_low(logic [1:0] m);
      (ctrl_q[1:0] == m && !freq_select_input)[*3];
   endsequence
   sequence susp_low;
      ((ctrl_q[1:0] == MODE_SUSPEND || (ctrl_q[1:0] == MODE_FREQ_SEL && ctrl_q[CTRL_SUSP_ALSO]))
         && !freq_select_input)[*3];
   endsequence
   a_ready_wait: assert property (access_start |-> !pready ##1 pready)
      else $error("pready not on second access edge");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ADDR_STATUS))
      else $error("pslverr wrong");
   a_oe_low: assert property (pin_low(MODE_OUT_EN) |=> oe == 3'h0)
      else $error("outputs driven with enable pin low");
   a_shutdown_float: assert property (pin_low(MODE_SHUTDOWN) |=> oe == 3'h0 && !crystal_feedback_pin_oe)
      else $error("pins driven in shutdown");
   a_suspend_float: assert property (susp_low |=> oe == ~ctrl_q[CTRL_SUSP_OUT_LSB +: 3])
      else $error("suspended output set wrong");
   a_xtal_write: assert property (wr && paddr == ADDR_XTAL |=> cap_load_code == wdata_q[5:0]
      && cap_bypass == wdata_q[6] && osc_drive == wdata_q[9:8])
      else $error("crystal fields not updated");
   a_bypass_fb: assert property (cap_bypass [*2] |-> !crystal_feedback_pin_oe)
      else $error("feedback pin driven in bypass");
endmodule : clock_synth_sva
bind three_pll_clock_synth clock_synth_sva clock_synth_sva_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .freq_select_input(freq_select_input), .clock_out_a_oe(clock_out_a_oe), .clock_out_b_oe(clock_out_b_oe),
   .clock_out_c_oe(clock_out_c_oe), .crystal_feedback_pin_oe(crystal_feedback_pin_oe),
   .cap_load_code(cap_load_code), .cap_bypass(cap_bypass), .osc_drive(osc_drive));
`default_nettype wire

// file: verif/clock_board_model.sv
/* Board side: reference clock source and control pin driver.
   Assumes the bench sets pin_level just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module clock_board_model
#(
   parameter int REF_HALF = 8
)
(
   input  wire logic mclk,
   input  wire logic pin_level,
   output logic      crystal_in_pin,
   output logic      freq_select_input
);
   int cnt = 0;
   initial crystal_in_pin = 1'b0;
   initial freq_select_input = 1'b1;
   // Free-running reference, REF_HALF mclk cycles per half period
   always @(posedge mclk)
   begin
      cnt <= (cnt == REF_HALF - 1) ? 0 : cnt + 1;
      if (cnt == REF_HALF - 1)
         crystal_in_pin <= ~crystal_in_pin;
      freq_select_input <= pin_level;
   end
endmodule : clock_board_model
`default_nettype wire

// file: verif/three_pll_clock_synth_tb_top.sv
/* Testbench: APB register tests, control pin functions and output rates.
   Assumes the bound checker and the board model beside the design. */
`timescale 1ns/1ps
`default_nettype none
`define check_eq(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module three_pll_clock_synth_tb_top
   import clock_synth_pkg::*;
;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pin_level = 1'b1;
   logic [31:0] prdata, r;
   logic        pready, pslverr, err, xin, fsin, xfb, xfb_oe, ca, ca_oe, cb, cb_oe, cc, cc_oe, byp;
   logic [5:0]  cap;
   logic [1:0]  drv;
   logic        cb_prev = 1'b0;
   int          num_errors = 0;
   int          compares = 0;
   int          cnt [3];
   int          run = 0;
   int          min_run = 999;
   logic [7:0]  ra [7] = '{ADDR_CTRL, ADDR_XTAL, ADDR_LOOP1_S0, ADDR_LOOP2, ADDR_XBAR, ADDR_DIV_A, ADDR_DIV_C};
   logic [31:0] rv [7] = '{32'h2, 32'h100, 32'h101, 32'h101, 32'h0, 32'h101, 32'h1};

   always #4 mclk = ~mclk;

   three_pll_clock_synth three_pll_clock_synth_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .crystal_in_pin(xin), .crystal_feedback_pin(xfb), .crystal_feedback_pin_oe(xfb_oe),
      .freq_select_input(fsin), .clock_out_a(ca), .clock_out_a_oe(ca_oe), .clock_out_b(cb),
      .clock_out_b_oe(cb_oe), .clock_out_c(cc), .clock_out_c_oe(cc_oe), .cap_load_code(cap),
      .cap_bypass(byp), .osc_drive(drv));
   clock_board_model #(.REF_HALF(8)) clock_board_model_i (.mclk(mclk), .pin_level(pin_level),
      .crystal_in_pin(xin), .freq_select_input(fsin));

   always @(posedge ca) cnt[0]++;
   always @(posedge cb) cnt[1]++;
   always @(posedge cc) cnt[2]++;
   // Shortest half period seen on output B
   always @(posedge mclk)
   begin
      cb_prev <= cb;
      if (cb !== cb_prev)
      begin
         if (run < min_run)
            min_run = run;
         run = 1;
      end
      else
         run++;
   end

   task automatic print_verdict;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      if (n >= 40)
         num_errors++;
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      `check_eq(nm, e, r & m)
   endtask : rd

   function automatic logic near(input int c, input int e);
      return c >= e - 2 && c <= e + 2;
   endfunction : near

   // Rising edges of A, B, C over 100 reference periods
   task automatic rates(input int ea, input int eb, input int ec);
      cnt = '{0, 0, 0};
      cyc(1600);
      `check_eq("rate a", 1'b1, near(cnt[0], ea))
      `check_eq("rate b", 1'b1, near(cnt[1], eb))
      `check_eq("rate c", 1'b1, near(cnt[2], ec))
   endtask : rates

   initial
   begin
      repeat (30000) @(posedge mclk);
      num_errors++;
      print_verdict();
   end

   initial
   begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      cyc(3);
      `check_eq("drive", 2'h1, drv)
      for (int i = 0; i < 7; i++)
         rd(ra[i], 32'hFFFF_FFFF, rv[i], "reset value");
      rd(8'h2C, 32'hFFFF_FFFF, 32'h0, "unmapped");
      `check_eq("slverr", 1'b1, err)
      apb(1'b1, ADDR_XTAL, 32'h0000_037F);
      cyc(3);
      `check_eq("xtal pins", 10'h37F, {drv, xfb_oe, byp, cap})
      rd(ADDR_XTAL, 32'hFFFF_FFFF, 32'h37F, "xtal");
      apb(1'b1, ADDR_XTAL, 32'h0000_0115);
      cyc(3);
      `check_eq("xtal pins", 10'h195, {drv, xfb_oe, byp, cap})
      @(posedge xin);
      cyc(4);
      `check_eq("fb", 1'b0, xfb)
      apb(1'b1, ADDR_LOOP2, 32'h0000_0201);
      apb(1'b1, ADDR_LOOP3, 32'h0000_0302);
      apb(1'b1, ADDR_LOOP1_S1, 32'h0000_0201);
      apb(1'b1, ADDR_XBAR, 32'h0000_0038);
      apb(1'b1, ADDR_DIV_B, 32'h0000_0102);
      apb(1'b1, ADDR_DIV_C, 32'h0000_0003);
      cyc(400);
      rates(100, 100, 50);
      apb(1'b1, ADDR_XBAR, 32'h0000_0031);
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      cyc(50);
      rates(200, 100, 50);
      rd(ADDR_STATUS, 32'h1, 32'h1, "fs level");
      min_run = 999;
      pin_level <= 1'b0;
      cyc(50);
      rates(100, 50, 50);
      `check_eq("min half", 1'b1, min_run >= 8)
      pin_level <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h0000_0002);
      pin_level <= 1'b0;
      cyc(6);
      `check_eq("oe", 3'h0, {ca_oe, cb_oe, cc_oe})
      rd(ADDR_STATUS, 32'h1C0, 32'h0, "status oe");
      pin_level <= 1'b1;
      cyc(6);
      `check_eq("oe", 3'h7, {ca_oe, cb_oe, cc_oe})
      apb(1'b1, ADDR_CTRL, 32'h0000_0491);
      pin_level <= 1'b0;
      cyc(6);
      `check_eq("oe", 3'h5, {ca_oe, cb_oe, cc_oe})
      `check_eq("inv b", 1'b1, cb)
      rd(ADDR_STATUS, 32'h1FE, 32'h16A, "suspend");
      pin_level <= 1'b1;
      cyc(400);
      rd(ADDR_STATUS, 32'h1FE, 32'h1CE, "relock");
      apb(1'b1, ADDR_CTRL, 32'h0000_0094);
      pin_level <= 1'b0;
      cyc(6);
      `check_eq("oe", 3'h5, {ca_oe, cb_oe, cc_oe})
      pin_level <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      pin_level <= 1'b0;
      cyc(6);
      `check_eq("oe", 4'h0, {ca_oe, cb_oe, cc_oe, xfb_oe})
      rd(ADDR_STATUS, 32'h1FE, 32'h10, "shutdown");
      pin_level <= 1'b1;
      cyc(400);
      rd(ADDR_STATUS, 32'h1FE, 32'h1CE, "relock");
      `check_eq("fb oe", 1'b1, xfb_oe)
      print_verdict();
   end
endmodule : three_pll_clock_synth_tb_top
`default_nettype wire
